// ---- hw/pmc_pkg.sv ----
// package for the power mode and emulation control block
package pmc_pkg;
  // aux register index; its byte address is four times the index
  localparam logic [7:0]  IDX_AUX_CONTROL  = 8'h8e;
  // register map (byte addresses)
  localparam logic [11:0] ADDR_AUX_CONTROL = {2'h0, IDX_AUX_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_MODE_CTRL   = 12'h090;
  localparam logic [11:0] ADDR_MODE_STAT   = 12'h094;
  // field positions
  localparam int AUX_ERED_BIT   = 0;
  localparam int CTL_IDLE_BIT   = 0;
  localparam int CTL_PDOWN_BIT  = 1;
  localparam int CTL_IRQ0_EN    = 2;
  localparam int CTL_IRQ1_EN    = 3;
  localparam int CTL_IRQ0_LVL   = 4;
  localparam int CTL_IRQ1_LVL   = 5;
  localparam int CTL_EXTPROG    = 6;
  // reset values
  localparam logic [7:0]  AUX_RESET  = 8'h00;
  localparam logic [7:0]  CTL_RESET  = 8'h00;
  // timing: clocks per machine cycle, reset hold, idle grace
  localparam int CLK_PER_MCYC       = 12;
  localparam int RST_HOLD_MCYC      = 2;
  localparam int RST_HOLD_CLKS      = CLK_PER_MCYC * RST_HOLD_MCYC;
  localparam int IDLE_GRACE_MCYC    = 2;
  localparam int IDLE_GRACE_CLKS    = CLK_PER_MCYC * IDLE_GRACE_MCYC;
  localparam int OSC_STABLE_MS      = 10;
  localparam int CLK_MHZ            = 10;
  localparam int OSC_STABLE_CLKS    = OSC_STABLE_MS * 1000 * CLK_MHZ;

  typedef enum logic [2:0] {
    PMC_RUN, PMC_IDLE, PMC_PDOWN, PMC_WAKE, PMC_RESET, PMC_EMUL
  } pmc_mode_t;

  // pin control bundle driven to the pad ring
  typedef struct packed {
    logic       strobe_val;   // address latch strobe level
    logic       strobe_weak;  // strobe weakly pulled high
    logic       prog_val;     // prog_store_strobe level
    logic       prog_weak;
    logic       port0_float;
    logic       port_weak;    // ports 1..3 weakly pulled high
    logic       port2_addr;   // port 2 carries address
  } pmc_pins_t;
endpackage : pmc_pkg

// ---- hw/pmc_top.sv ----
// power mode and emulation control with an apb register slave
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
module pmc_top (
  // apb
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // pins
  input  wire logic              rst_pin,
  input  wire logic              strobe_in,
  input  wire logic              prog_store_strobe_in,
  input  wire logic              ext_irq_zero,
  input  wire logic              ext_irq_one,
  // core side
  input  wire logic              core_strobe,
  input  wire logic              core_prog_strobe,
  input  wire logic              core_fetch,
  input  wire logic              irq_return,
  output logic                   osc_run,
  output logic                   core_halt,
  output logic                   sfr_reset,
  output logic                   ram_block,
  output logic                   wake_irq,
  output logic                   resume_next,
  output pmc_pkg::pmc_pins_t     pins,
  output pmc_pkg::pmc_mode_t     mode
);
  pmc_pkg::pmc_mode_t mode_q;
  logic [7:0]  aux_q;
  logic [7:0]  ctl_q;
  logic [15:0] rst_cnt_q;
  logic        int_reset_q;
  logic        emul_q;
  logic        rst_d1_q;
  logic        emul_cand_q;
  logic [15:0] grace_q;
  logic        resume_q;
  logic        wake_low_q;
  logic        wake_line;
  logic        wr_en;

  function automatic logic line_armed(input logic en, input logic lvl, input logic pin);
    line_armed = en && lvl && !pin;
  endfunction : line_armed

  ////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel && penable && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_q <= pmc_pkg::AUX_RESET;
    end else if (int_reset_q) begin
      aux_q <= pmc_pkg::AUX_RESET;
    end else if (wr_en && paddr == pmc_pkg::ADDR_AUX_CONTROL) begin
      aux_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= pmc_pkg::CTL_RESET;
    end else if (int_reset_q) begin
      ctl_q <= pmc_pkg::CTL_RESET;
    end else if (mode_q == pmc_pkg::PMC_WAKE) begin
      ctl_q[pmc_pkg::CTL_PDOWN_BIT] <= 1'b0;
    end else if (mode_q == pmc_pkg::PMC_RUN && wr_en && paddr == pmc_pkg::ADDR_MODE_CTRL) begin
      ctl_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        pmc_pkg::ADDR_AUX_CONTROL: prdata <= {24'h000000, aux_q};
        pmc_pkg::ADDR_MODE_CTRL:   prdata <= {24'h000000, ctl_q};
        pmc_pkg::ADDR_MODE_STAT:   prdata <= {28'h0000000, emul_q, mode_q};
        default:                   prdata <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // reset pin qualification
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_q   <= '0;
      int_reset_q <= 1'b0;
    end else if (!rst_pin) begin
      rst_cnt_q   <= '0;
      int_reset_q <= 1'b0;
    end else if (rst_cnt_q < 16'(pmc_pkg::RST_HOLD_CLKS - 1)) begin
      rst_cnt_q   <= rst_cnt_q + 16'h0001;
    end else begin
      int_reset_q <= 1'b1;
    end
  end

  // emulation entry sampled during reset, latched at release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_d1_q    <= 1'b0;
      emul_cand_q <= 1'b0;
      emul_q      <= 1'b0;
    end else begin
      rst_d1_q <= int_reset_q;
      if (int_reset_q) begin
        emul_cand_q <= !strobe_in && prog_store_strobe_in;
        emul_q      <= 1'b0;
      end else if (rst_d1_q) begin
        emul_q <= emul_cand_q && !strobe_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // mode machine
  assign wake_line = line_armed(ctl_q[pmc_pkg::CTL_IRQ0_EN], ctl_q[pmc_pkg::CTL_IRQ0_LVL],
                                ext_irq_zero) ||
                     line_armed(ctl_q[pmc_pkg::CTL_IRQ1_EN], ctl_q[pmc_pkg::CTL_IRQ1_LVL],
                                ext_irq_one);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q     <= pmc_pkg::PMC_RESET;
      grace_q    <= '0;
      wake_low_q <= 1'b0;
    end else begin
      unique case (mode_q)
        pmc_pkg::PMC_RUN: begin
          if (int_reset_q) mode_q <= pmc_pkg::PMC_RESET;
          else if (ctl_q[pmc_pkg::CTL_PDOWN_BIT]) mode_q <= pmc_pkg::PMC_PDOWN;
          else if (ctl_q[pmc_pkg::CTL_IDLE_BIT]) mode_q <= pmc_pkg::PMC_IDLE;
        end
        pmc_pkg::PMC_IDLE: begin
          if (rst_pin) begin
            // core may run on briefly before internal reset
            if (grace_q < 16'(pmc_pkg::IDLE_GRACE_CLKS)) grace_q <= grace_q + 16'h0001;
            else mode_q <= pmc_pkg::PMC_RESET;
          end else begin
            grace_q <= '0;
            if (wake_line) mode_q <= pmc_pkg::PMC_RUN;
          end
        end
        pmc_pkg::PMC_PDOWN: begin
          if (rst_pin) mode_q <= pmc_pkg::PMC_RESET;
          else if (wake_line) begin
            wake_low_q <= 1'b1;
            mode_q     <= pmc_pkg::PMC_WAKE;
          end
        end
        pmc_pkg::PMC_WAKE: begin
          if (rst_pin) mode_q <= pmc_pkg::PMC_RESET;
          else if (!wake_line) begin
            wake_low_q <= 1'b0;
            mode_q     <= pmc_pkg::PMC_RUN;
          end
        end
        pmc_pkg::PMC_RESET: begin
          grace_q <= '0;
          if (!rst_pin && !int_reset_q)
            mode_q <= emul_cand_q && !strobe_in ? pmc_pkg::PMC_EMUL : pmc_pkg::PMC_RUN;
        end
        pmc_pkg::PMC_EMUL: begin
          if (int_reset_q) mode_q <= pmc_pkg::PMC_RESET;
        end
        default: mode_q <= pmc_pkg::PMC_RESET;
      endcase
    end
  end

  // resume point after wake interrupt returns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_q <= 1'b0;
    end else if (mode_q == pmc_pkg::PMC_WAKE && !wake_line) begin
      resume_q <= 1'b1;
    end else if (irq_return || int_reset_q) begin
      resume_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign mode        = mode_q;
  assign osc_run     = mode_q != pmc_pkg::PMC_PDOWN;
  assign core_halt   = mode_q inside {pmc_pkg::PMC_PDOWN, pmc_pkg::PMC_WAKE, pmc_pkg::PMC_EMUL}
                       || (mode_q == pmc_pkg::PMC_IDLE && !rst_pin);
  assign sfr_reset   = int_reset_q;
  assign ram_block   = mode_q == pmc_pkg::PMC_IDLE && rst_pin;
  assign wake_irq    = wake_low_q;
  assign resume_next = resume_q;

  always_comb begin
    pins = '0;
    pins.strobe_val = core_strobe;
    pins.prog_val   = core_prog_strobe;
    pins.port0_float = ctl_q[pmc_pkg::CTL_EXTPROG];
    if (aux_q[pmc_pkg::AUX_ERED_BIT] && core_fetch) begin
      pins.strobe_val  = 1'b1;
      pins.strobe_weak = 1'b1;
    end
    unique case (mode_q)
      pmc_pkg::PMC_IDLE: begin
        pins.strobe_val = 1'b1;
        pins.prog_val   = 1'b1;
        pins.port2_addr = ctl_q[pmc_pkg::CTL_EXTPROG];
      end
      pmc_pkg::PMC_PDOWN, pmc_pkg::PMC_WAKE: begin
        pins.strobe_val = 1'b0;
        pins.prog_val   = 1'b0;
        pins.strobe_weak = 1'b0;
      end
      pmc_pkg::PMC_EMUL: begin
        pins.strobe_val  = 1'b1;
        pins.strobe_weak = 1'b1;
        pins.prog_val    = 1'b1;
        pins.prog_weak   = 1'b1;
        pins.port0_float = 1'b1;
        pins.port_weak   = 1'b1;
      end
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // assertions
  // reset pin high for two machine cycles
  sequence s_pin_held;
    rst_pin [*8] ##1 rst_pin [*8] ##1 rst_pin [*8];
  endsequence
  property p_rst_hold;
    @(posedge pclk) disable iff (!presetn)
      !rst_pin ##1 s_pin_held |-> ##1 int_reset_q;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset not taken");

  property p_pdown_osc;
    @(posedge pclk) disable iff (!presetn) mode_q == pmc_pkg::PMC_PDOWN |-> !osc_run;
  endproperty
  a_pdown_osc: assert property (p_pdown_osc) else $error("osc runs in power down");

  property p_pdown_exit;
    @(posedge pclk) disable iff (!presetn)
      mode_q == pmc_pkg::PMC_PDOWN && !rst_pin && !wake_line |=> mode_q == pmc_pkg::PMC_PDOWN;
  endproperty
  a_pdown_exit: assert property (p_pdown_exit) else $error("spurious power down exit");

  property p_wake_keep;
    @(posedge pclk) disable iff (!presetn)
      mode_q == pmc_pkg::PMC_WAKE && !wake_line && !rst_pin
        |=> mode_q == pmc_pkg::PMC_RUN && $stable(aux_q) && resume_q;
  endproperty
  a_wake_keep: assert property (p_wake_keep) else $error("wake exit lost state");

  property p_aux_clr;
    @(posedge pclk) disable iff (!presetn) int_reset_q |=> aux_q == pmc_pkg::AUX_RESET;
  endproperty
  a_aux_clr: assert property (p_aux_clr) else $error("aux not cleared");

  property p_ered;
    @(posedge pclk) disable iff (!presetn)
      mode_q == pmc_pkg::PMC_RUN && aux_q[pmc_pkg::AUX_ERED_BIT] && core_fetch
        |-> pins.strobe_val && pins.strobe_weak;
  endproperty
  a_ered: assert property (p_ered) else $error("strobe not suppressed");

  property p_idle_pins;
    @(posedge pclk) disable iff (!presetn)
      mode_q == pmc_pkg::PMC_IDLE |-> pins.strobe_val && pins.prog_val;
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("idle strobes not high");

  property p_emul_pins;
    @(posedge pclk) disable iff (!presetn)
      mode_q == pmc_pkg::PMC_EMUL |-> pins.port0_float && pins.port_weak && osc_run;
  endproperty
  a_emul_pins: assert property (p_emul_pins) else $error("emulation pins wrong");

  property p_emul_exit;
    @(posedge pclk) disable iff (!presetn)
      mode_q == pmc_pkg::PMC_EMUL && int_reset_q |=> mode_q == pmc_pkg::PMC_RESET && !emul_q;
  endproperty
  a_emul_exit: assert property (p_emul_exit) else $error("emulation kept through reset");
endmodule : pmc_top

// ---- tb/pmc_partner.sv ----
// model of the reset source, wake interrupt source and emulator around the block
`timescale 1ns/100ps
module pmc_partner #(
  parameter int HOLD_CLKS = 30,
  parameter int OSC_CLKS  = 40
) (
  // clock
  input  wire logic pclk,
  // pins toward the block
  output logic      rst_pin,
  output logic      strobe_in,
  output logic      prog_store_strobe_in,
  output logic      ext_irq_zero,
  output logic      ext_irq_one
);
  // pulled-up lines idle high, reset pin pulled down
  initial begin
    rst_pin              = 1'b0;
    strobe_in            = 1'b1;
    prog_store_strobe_in = 1'b1;
    ext_irq_zero         = 1'b1;
    ext_irq_one          = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // reset held past two machine cycles; emulator holds strobe low across release
  task pulse_reset(input bit emul, input bit prog);
    @(posedge pclk);
    rst_pin              <= 1'b1;
    strobe_in            <= ~emul;
    prog_store_strobe_in <= prog;
    repeat (HOLD_CLKS) @(posedge pclk);
    rst_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    strobe_in            <= 1'b1;
    prog_store_strobe_in <= 1'b1;
  endtask : pulse_reset
  // wake line held low until the oscillator has settled, then released
  task wake(input bit line);
    @(posedge pclk);
    if (line) ext_irq_one <= 1'b0;
    else ext_irq_zero <= 1'b0;
    repeat (OSC_CLKS) @(posedge pclk);
    ext_irq_zero <= 1'b1;
    ext_irq_one  <= 1'b1;
  endtask : wake
endmodule : pmc_partner

// ---- tb/testbench.sv ----
// self-checking bench for the power mode and emulation control block
`timescale 1ns/100ps
module testbench;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rd;
  logic                rst_pin, strobe_in, prog_in, irq0, irq1;
  logic                core_strobe, core_prog, core_fetch, irq_return;
  logic                osc_run, core_halt, sfr_reset, ram_block, wake_irq, resume_next;
  pmc_pkg::pmc_pins_t  pins;
  pmc_pkg::pmc_mode_t  mode;
  int                  fails, cmp_count;

  pmc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .rst_pin(rst_pin), .strobe_in(strobe_in),
    .prog_store_strobe_in(prog_in), .ext_irq_zero(irq0), .ext_irq_one(irq1),
    .core_strobe(core_strobe), .core_prog_strobe(core_prog), .core_fetch(core_fetch),
    .irq_return(irq_return), .osc_run(osc_run), .core_halt(core_halt),
    .sfr_reset(sfr_reset), .ram_block(ram_block), .wake_irq(wake_irq),
    .resume_next(resume_next), .pins(pins), .mode(mode));
  pmc_partner partner (.pclk(pclk), .rst_pin(rst_pin), .strobe_in(strobe_in),
    .prog_store_strobe_in(prog_in), .ext_irq_zero(irq0), .ext_irq_one(irq1));

  always #50 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task final_report;
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tick
  // apb transfer: setup, access until pready sampled high, then release
  task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    chk("pready", 32'(pready), 32'h1);
    chk("pslverr", 32'(pslverr), 32'h0);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_mode(input pmc_pkg::pmc_mode_t m);
    int n;
    n = 0;
    #1;
    while (mode !== m && n < 300) begin
      tick(1);
      n++;
    end
    chk("mode reached", 32'(mode), 32'(m));
  endtask : wait_mode
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk        = 1'b0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h00000000;
    core_strobe = 1'b1;
    core_prog   = 1'b1;
    core_fetch  = 1'b1;
    irq_return  = 1'b0;
    fails       = 0;
    cmp_count   = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, pmc_pkg::ADDR_AUX_CONTROL, 8'h00);
    chk("aux rst", rd, 32'h0);
    apb(1, 12'h0a0, 8'hff);
    apb(0, 12'h0a0, 8'h00);
    chk("unmapped", rd, 32'h0);
    // strobe suppression during fetch, internal program memory only
    apb(1, pmc_pkg::ADDR_AUX_CONTROL, 8'h01);
    tick(2);
    chk("supp", {pins.strobe_val, pins.strobe_weak}, 32'h3);
    @(posedge pclk);
    core_fetch <= 1'b0;
    tick(1);
    chk("no fetch", {pins.strobe_val, pins.strobe_weak}, 32'h2);
    @(posedge pclk);
    core_fetch <= 1'b1;
    apb(1, pmc_pkg::ADDR_AUX_CONTROL, 8'h00);
    tick(2);
    chk("unsupp", {pins.strobe_val, pins.strobe_weak}, 32'h2);
    apb(1, pmc_pkg::ADDR_AUX_CONTROL, 8'h01);
    tick(20);
    chk("persist", 32'(pins.strobe_weak), 32'h1);
    // power down with enabled level wake on line zero
    apb(1, pmc_pkg::ADDR_MODE_CTRL, 8'h16);
    wait_mode(pmc_pkg::PMC_PDOWN);
    chk("pd pins", {osc_run, pins.strobe_val, pins.prog_val, pins.port0_float,
      pins.port2_addr, core_halt}, 32'h01);
    fork
      partner.wake(0);
      begin
        tick(6);
        chk("wake", {mode, wake_irq, osc_run, core_halt},
          {26'h0, pmc_pkg::PMC_WAKE, 3'b111});
      end
    join
    wait_mode(pmc_pkg::PMC_RUN);
    chk("resume", 32'(resume_next), 32'h1);
    chk("wake end", 32'(wake_irq), 32'h0);
    apb(0, pmc_pkg::ADDR_MODE_CTRL, 8'h00);
    chk("ctl", rd, 32'h14);
    apb(0, pmc_pkg::ADDR_AUX_CONTROL, 8'h00);
    chk("aux kept", rd, 32'h1);
    @(posedge pclk);
    irq_return <= 1'b1;
    @(posedge pclk);
    irq_return <= 1'b0;
    tick(2);
    chk("resume end", 32'(resume_next), 32'h0);
    // power down, wake lines not armed, external program memory
    apb(1, pmc_pkg::ADDR_AUX_CONTROL, 8'h00);
    apb(1, pmc_pkg::ADDR_MODE_CTRL, 8'h5a);
    wait_mode(pmc_pkg::PMC_PDOWN);
    chk("pd ext pins", {osc_run, pins.strobe_val, pins.prog_val, pins.port0_float,
      pins.port2_addr}, 32'h02);
    partner.wake(0);
    partner.wake(1);
    tick(3);
    chk("no wake", 32'(mode), 32'(pmc_pkg::PMC_PDOWN));
    fork
      partner.pulse_reset(0, 1);
      begin
        tick(27);
        chk("sfr rst", 32'(sfr_reset), 32'h1);
      end
    join
    wait_mode(pmc_pkg::PMC_RUN);
    chk("sfr rel", 32'(sfr_reset), 32'h0);
    apb(0, pmc_pkg::ADDR_MODE_CTRL, 8'h00);
    chk("ctl clr", rd, 32'h0);
    // idle with external program memory, ended by reset
    @(posedge pclk);
    core_strobe <= 1'b0;
    core_prog   <= 1'b0;
    tick(1);
    chk("core strobes", {pins.strobe_val, pins.prog_val}, 32'h0);
    apb(1, pmc_pkg::ADDR_MODE_CTRL, 8'h41);
    wait_mode(pmc_pkg::PMC_IDLE);
    chk("idle pins", {pins.strobe_val, pins.prog_val, pins.port0_float,
      pins.port2_addr, core_halt}, 32'h1f);
    fork
      partner.pulse_reset(0, 1);
      begin
        tick(4);
        chk("ram blk", {ram_block, core_halt}, 32'h2);
      end
    join
    wait_mode(pmc_pkg::PMC_RUN);
    chk("run", 32'(mode), 32'(pmc_pkg::PMC_RUN));
    apb(0, pmc_pkg::ADDR_MODE_CTRL, 8'h00);
    chk("idle clr", rd, 32'h0);
    // emulation entry, latch at release, exit by normal reset
    apb(1, pmc_pkg::ADDR_AUX_CONTROL, 8'h01);
    partner.pulse_reset(1, 1);
    wait_mode(pmc_pkg::PMC_EMUL);
    tick(6);
    chk("emul", {mode, pins.port0_float, pins.port_weak, pins.strobe_weak, pins.prog_weak,
      osc_run}, {24'h0, pmc_pkg::PMC_EMUL, 5'h1f});
    chk("emul halt", 32'(core_halt), 32'h1);
    apb(0, pmc_pkg::ADDR_AUX_CONTROL, 8'h00);
    chk("aux clr", rd, 32'h0);
    apb(0, pmc_pkg::ADDR_MODE_STAT, 8'h00);
    chk("stat emul", rd, {28'h0, 1'b1, pmc_pkg::PMC_EMUL});
    partner.pulse_reset(0, 1);
    wait_mode(pmc_pkg::PMC_RUN);
    chk("emul exit", 32'(mode), 32'(pmc_pkg::PMC_RUN));
    apb(0, pmc_pkg::ADDR_MODE_STAT, 8'h00);
    chk("stat run", rd, {28'h0, 1'b0, pmc_pkg::PMC_RUN});
    // strobe low but prog strobe low during reset: no emulation
    partner.pulse_reset(1, 0);
    wait_mode(pmc_pkg::PMC_RUN);
    apb(0, pmc_pkg::ADDR_MODE_STAT, 8'h00);
    chk("no emul", rd, {28'h0, 1'b0, pmc_pkg::PMC_RUN});
    final_report();
  end
  initial begin
    repeat (4000) @(posedge pclk);
    fails++;
    final_report();
  end
endmodule : testbench
